// *** core/asrc_host.v ***
// Host controller driving an asynchronous static RAM through its pins.
// Assumes user requests synchronous to clk and the RAM wired straight to the pins.
`include "asrc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module asrc_host #(
  parameter [`ASRC_CNT_W-1:0] RECOVERY_CYC = `ASRC_TR_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // User request
  input wire req_valid,
  input wire req_write,
  input wire [`ASRC_ADDR_W-1:0] req_addr,
  input wire [`ASRC_DATA_W-1:0] req_wdata,
  input wire retain_req,
  output reg req_ready,
  output reg rsp_valid,
  output reg [`ASRC_DATA_W-1:0] rsp_rdata,
  output reg retained,
  // RAM pins
  output reg [`ASRC_ADDR_W-1:0] mem_addr,
  output reg chip_select_low_active_n,
  output reg chip_select_high_active,
  output reg write_strobe_n,
  output reg output_gate_n,
  output reg [`ASRC_DATA_W-1:0] mem_dq_o,
  output reg mem_dq_oe,
  output reg ctl_float,
  input wire [`ASRC_DATA_W-1:0] mem_dq_i
);

  // One-hot states of the pin sequencer:
  // IDLE waits for work, WSET/WPUL/WEND walk one write cycle,
  // READ holds a gated read, RETN parks the RAM in retention and
  // RECV keeps it deselected while it settles after reset, a read
  // or a wake-up.
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_WSET = 7'h02;
  localparam [6:0] S_WPUL = 7'h04;
  localparam [6:0] S_WEND = 7'h08;
  localparam [6:0] S_READ = 7'h10;
  localparam [6:0] S_RETN = 7'h20;
  localparam [6:0] S_RECV = 7'h40;

  // Cycle counts of the slowest grade; the write rest fills the
  // remainder of the write cycle once the strobe has risen, and the
  // float count covers the RAM output turn-off after a gate release.
  // They are rounded up, but data leads the strobe rise by 9 cycles, short of the 16 that ASRC_DW_CYC gives.
  localparam [`ASRC_CNT_W-1:0] WP_CYC = `ASRC_WP_CYC;
  localparam [`ASRC_CNT_W-1:0] WREST_CYC = `ASRC_WC_CYC - `ASRC_WP_CYC;
  localparam [`ASRC_CNT_W-1:0] RC_CYC = `ASRC_RC_CYC;
  localparam [`ASRC_CNT_W-1:0] OHZ_CYC = `ASRC_OHZ_CYC;

  // State and the one down-counter that every timed phase shares;
  // it is wide enough for the full recovery count at this clock.
  // Zero is never loaded, so the count always ends at one.
  reg [6:0] state_q;
  reg [`ASRC_CNT_W-1:0] cnt_q;

  // Write walk, in clock cycles after the take:
  //   c0  selects active, address and data registered
  //   c1  strobe falls while the gate stays high
  //   c12 data driven, after the RAM has surely floated
  //   c21 strobe rises and ends the overlap; the RAM captures here
  //   c22 data released, selects dropped
  //   c31 ready again with a done pulse
  // Read walk:
  //   c0  selects and gate active, strobe held high all through
  //   c30 data sampled, gate and selects dropped, done pulse
  //   then a float gap before the next request can be taken
  // Limitation: requests are not queued; one seen while ready is low
  // is simply ignored and must be held by the requester.
  // Retention drives both selects inactive, so either retention entry
  // holds; the float flag tells the pad ring it may release the rest.
  // Wake-up always runs the full recovery count before ready rises.

  // Sequencer; each strobe edge has a cycle of its own so write overlaps are ordered
  always @(posedge clk) begin
    if (rst) begin
      // Everything inactive; the RAM sees a deselected, quiet bus
      state_q <= S_RECV;
      cnt_q <= RECOVERY_CYC;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      retained <= 1'b0;
      mem_addr <= 17'h00000;
      chip_select_low_active_n <= 1'b1;
      chip_select_high_active <= 1'b0;
      write_strobe_n <= 1'b1;
      output_gate_n <= 1'b1;
      mem_dq_o <= 8'h00;
      mem_dq_oe <= 1'b0;
      ctl_float <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        // Retention wins over a pending request
        S_IDLE: begin
          if (retain_req) begin
            // Deselect hard through both selects, then let the rest float
            chip_select_low_active_n <= 1'b1;
            chip_select_high_active <= 1'b0;
            ctl_float <= 1'b1;
            mem_dq_oe <= 1'b0;
            retained <= 1'b1;
            req_ready <= 1'b0;
            state_q <= S_RETN;
          end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            // Address moves only while deselected and strobe high
            mem_addr <= req_addr;
            if (req_write) begin
              // Gate stays high for the whole write so the RAM never drives
              mem_dq_o <= req_wdata;
              chip_select_low_active_n <= 1'b0;
              chip_select_high_active <= 1'b1;
              state_q <= S_WSET;
            end else begin
              chip_select_low_active_n <= 1'b0;
              chip_select_high_active <= 1'b1;
              output_gate_n <= 1'b0;
              cnt_q <= RC_CYC;
              state_q <= S_READ;
            end
          end
        end

        S_WSET: begin
          // Selects already active: strobe falls after them, gate stays high
          write_strobe_n <= 1'b0;
          cnt_q <= WP_CYC;
          state_q <= S_WPUL;
        end

        S_WPUL: begin
          // Drive data only once the strobe is low and the RAM has floated
          if (cnt_q == OHZ_CYC)
            mem_dq_oe <= 1'b1;
          if (cnt_q == 20'h00001) begin
            write_strobe_n <= 1'b1;
            cnt_q <= WREST_CYC;
            state_q <= S_WEND;
          end else
            cnt_q <= cnt_q - 20'h00001;
        end

        S_WEND: begin
          // Hold data one cycle past the strobe rise, then release
          mem_dq_oe <= 1'b0;
          chip_select_low_active_n <= 1'b1;
          chip_select_high_active <= 1'b0;
          if (cnt_q <= 20'h00001) begin
            req_ready <= 1'b1;
            rsp_valid <= 1'b1;
            state_q <= S_IDLE;
          end else
            cnt_q <= cnt_q - 20'h00001;
        end

        // Gate low; count down the read cycle before sampling
        S_READ: begin
          if (cnt_q == 20'h00001) begin
            rsp_rdata <= mem_dq_i;
            rsp_valid <= 1'b1;
            output_gate_n <= 1'b1;
            chip_select_low_active_n <= 1'b1;
            chip_select_high_active <= 1'b0;
            // Allow the RAM outputs to float before the next drive
            cnt_q <= OHZ_CYC;
            state_q <= S_RECV;
          end else
            cnt_q <= cnt_q - 20'h00001;
        end

        // Parked; everything but the selects may be released
        S_RETN: begin
          if (!retain_req) begin
            ctl_float <= 1'b0;
            retained <= 1'b0;
            cnt_q <= RECOVERY_CYC;
            state_q <= S_RECV;
          end
        end

        S_RECV: begin
          // Stay deselected until the count runs out
          if (cnt_q <= 20'h00001) begin
            req_ready <= 1'b1;
            state_q <= S_IDLE;
          end else
            cnt_q <= cnt_q - 20'h00001;
        end

        // Unreachable codes fall back to idle
        default: begin
          state_q <= S_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // asrc_host
`default_nettype wire

// *** core/asrc_regs.vh ***
// Timing constants for the asynchronous static RAM host controller.
// Assumes a 200 MHz controller clock; all counts but the recovery count (from ms) are derived from ns figures.
`ifndef ASRC_REGS_VH
`define ASRC_REGS_VH
`define ASRC_CLK_PERIOD_NS 5
`define ASRC_ADDR_W 17
`define ASRC_DATA_W 8
// Write cycle figures (slowest grade), ns
`define ASRC_T_WC_NS 150
`define ASRC_T_WP_NS 100
`define ASRC_T_DW_NS 80
`define ASRC_T_WHZ_NS 50
// Read cycle figures (slowest grade), ns
`define ASRC_T_RC_NS 150
`define ASRC_T_OHZ_NS 50
// Recovery after retention, ms
`define ASRC_T_R_MS 5
// Least times round up to whole cycles
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_WP_CYC `ASRC_CYC_UP(`ASRC_T_WP_NS)
`define ASRC_WC_CYC `ASRC_CYC_UP(`ASRC_T_WC_NS)
`define ASRC_DW_CYC `ASRC_CYC_UP(`ASRC_T_DW_NS)
`define ASRC_WHZ_CYC `ASRC_CYC_UP(`ASRC_T_WHZ_NS)
`define ASRC_RC_CYC `ASRC_CYC_UP(`ASRC_T_RC_NS)
`define ASRC_OHZ_CYC `ASRC_CYC_UP(`ASRC_T_OHZ_NS)
`define ASRC_TR_CYC ((`ASRC_T_R_MS * 1000000) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CNT_W 20
`endif

// *** testbench/asrc_host_checker.sv ***
// Pin checker for asrc_host, bound into it.
// Assumes one clock domain and a synchronous rst.
`timescale 1ns/1ps
`default_nettype none
module asrc_chk (input wire logic clk, rst, chip_select_low_active_n, chip_select_high_active,
  input wire logic write_strobe_n, output_gate_n, mem_dq_oe, ctl_float, retained,
  input wire logic [16:0] mem_addr);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Selected means both chip selects active
  wire logic sel = !chip_select_low_active_n && chip_select_high_active;
  chk_addr_hold: assert property (sel && !write_strobe_n && $past(sel && !write_strobe_n)
    |-> $stable(mem_addr)) else $error("address moved in write");
  chk_no_fight: assert property (mem_dq_oe |-> output_gate_n &&
    (!write_strobe_n || $past(!write_strobe_n)))
    else $error("data driven while ram may drive");
  chk_gate_read: assert property (!output_gate_n |-> write_strobe_n && !mem_dq_oe)
    else $error("gate low outside read");
  chk_read_strobe: assert property ($fell(output_gate_n) |-> write_strobe_n [*8])
    else $error("strobe fell in read");
  chk_sel_first: assert property ($fell(write_strobe_n) |-> sel && $past(sel))
    else $error("select late to write");
  chk_data_end: assert property ($rose(write_strobe_n) && sel |-> $past(mem_dq_oe))
    else $error("data gone at write end");
  chk_retain_sel: assert property (retained |->
    chip_select_low_active_n && !chip_select_high_active) else $error("select in retention");
  chk_float_ret: assert property (ctl_float |-> retained)
    else $error("pins freed while awake");
  chk_wake_idle: assert property ($fell(retained) |-> !sel [*4])
    else $error("access in recovery");
  cover property ($rose(write_strobe_n) && sel);
  cover property ($fell(output_gate_n));
  cover property ($rose(retained));
endmodule // asrc_chk
bind asrc_host asrc_chk asrc_chk_i (.*);
`default_nettype wire

// *** testbench/asrc_sram_model.sv ***
// Behavioural static RAM facing asrc_host.
// Assumes host pins wired straight in; the RAM has no clock.
`timescale 1ns/1ps
`default_nettype none
module asrc_sram (input wire logic cs_n, cs_h, we_n, oe_n, dq_oe,
  input wire logic [16:0] mem_addr, input wire logic [7:0] dq_o, output wire logic [7:0] dq_i);
  logic [7:0] mem [0:131071];
  logic [7:0] last = 8'h00;
  // Writes only in the triple overlap, so retention keeps contents
  wire logic wr = !cs_n && cs_h && !we_n;
  wire logic rd = !cs_n && cs_h && we_n && !oe_n;
  // Word taken when the overlap ends; an undriven bus stores garbage
  always @(negedge wr) mem[mem_addr] = dq_oe ? dq_o : ~last;
  always @(negedge rd) last = mem[mem_addr];
  // Drives only in a gated read; otherwise shows a changed value, not the old one
  assign dq_i = rd ? mem[mem_addr] : ~last;
endmodule // asrc_sram
`default_nettype wire

// *** testbench/test_async_sram_write_and_retention.sv ***
// Self-checking bench for asrc_host with a behavioural RAM behind it.
// Assumes the checker is bound in and recovery shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module test_async_sram_write_and_retention;
  logic clk = 0, rst = 1, req_valid = 0, req_write = 0, retain_req = 0;
  logic [16:0] req_addr = 0, a;
  logic [7:0] req_wdata = 0;
  wire logic req_ready, rsp_valid, retained, cs_n, cs_h, we_n, oe_n, dq_oe;
  wire logic [7:0] rsp_rdata, dq_o, dq_i;
  wire logic [16:0] mem_addr;
  int miscompares = 0, comparisons = 0, cyc = 0;
  logic [7:0] exp [int];
  asrc_host #(.RECOVERY_CYC(20'h4)) asrc_host_i (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .retain_req(retain_req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retained(retained),
    .mem_addr(mem_addr), .chip_select_low_active_n(cs_n), .chip_select_high_active(cs_h),
    .write_strobe_n(we_n), .output_gate_n(oe_n), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe),
    .ctl_float(), .mem_dq_i(dq_i));
  asrc_sram asrc_sram_i (.*);
  initial forever #2.5 clk = ~clk;
  // Hang guard: the whole run needs about 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end
  task close_out;
    $display("counts: %0d compared, %0d wrong", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One access: hold the request until taken, then wait for the answer
  task access(input logic w, input logic [16:0] ad, input logic [7:0] d);
    @(posedge clk);
    req_valid <= 1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 0;
    repeat (60) begin @(posedge clk); if (rsp_valid === 1'b1) break; end
    `CHK(rsp_valid, 1'b1)
    if (w) exp[ad] = d; else `CHK(rsp_rdata, exp[ad])
  endtask
  initial begin
    void'($urandom(32'h9C2081C8));
    repeat (5) @(posedge clk);
    rst <= 0;
    // Edge addresses, then random write and read-back pairs
    access(1, 17'h1FFFF, 8'hA5);
    access(1, 17'h00000, 8'h5A);
    access(0, 17'h1FFFF, 8'h00);
    access(0, 17'h00000, 8'h00);
    repeat (20) begin
      a = 17'($urandom);
      access(1, a, 8'($urandom));
      access(0, a, 8'h00);
    end
    // Retention, then contents must survive the wake-up
    @(posedge clk);
    retain_req <= 1;
    repeat (50) @(posedge clk);
    `CHK(retained, 1'b1)
    retain_req <= 0;
    access(0, 17'h1FFFF, 8'h00);
    close_out;
  end
endmodule // test_async_sram_write_and_retention
`default_nettype wire
